// *** logic/pvd_pkg.sv ***
// types shared by the pvd block
package pvd_pkg;
  typedef struct packed {
    logic cfg;
    logic write;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pvd_req_type;
  typedef struct packed {
    logic write;
    logic [1:0] chan;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pvd_mst_type;
  typedef enum logic [4:0] {
    LD_START = 5'b00001,
    LD_TX = 5'b00010,
    LD_RX = 5'b00100,
    LD_STOP = 5'b01000,
    LD_DONE = 5'b10000
  } pvd_ld_type;
endpackage

// *** logic/pvd_regs.svh ***
// register offsets, fields, reset values and timing for the pvd block
`ifndef PVD_REGS_SVH
`define PVD_REGS_SVH
// configuration space byte offsets
`define PVD_CFG_IDENT 8'h00
`define PVD_CFG_STCMD 8'h04
`define PVD_CFG_CLASS 8'h08
`define PVD_CFG_LAT 8'h0C
`define PVD_CFG_BAR 8'h10
`define PVD_CFG_SUBSYS 8'h2C
`define PVD_CFG_INTR 8'h3C
`define PVD_CLASS_CODE 24'h048000
`define PVD_INT_PIN 8'h01
`define PVD_MAXLAT_RST 8'h26
`define PVD_MINGNT_RST 8'h0F
`define PVD_BAR_LSB 9
// memory window byte offsets of the channel programming sets
`define PVD_CH_STRIDE 9'h018
`define PVD_EXT_BASE 9'h100
`define PVD_EXT_STRIDE 9'h010
`define PVD_EXT_STAT 9'h008
// control word fields
`define PVD_CTL_TREN 0
`define PVD_CTL_READ 1
`define PVD_CTL_REP_LSB 2
`define PVD_CTL_WMASK_CH1 32'h0000_0001
`define PVD_CTL_WMASK_CH2 32'h0000_0003
`define PVD_CTL_WMASK_CH3 32'h0000_FF0F
`define PVD_PROT_WMASK 32'hFFFF_FFFC
`define PVD_PAGE_WMASK 32'hFFFF_F8FB
`define PVD_LB_WMASK 32'h0FFF_0FFF
`define PVD_TB_WMASK 32'h0000_FFFF
// fifo
`define PVD_FIFO_DEPTH 8'd128
`define PVD_FIFO_NEAR_FULL 8'd127
// serial eeprom loader
`define PVD_EE_WR_ADDR 8'hA0
`define PVD_EE_RD_ADDR 8'hA1
`define PVD_EE_WORD 8'h00
`define PVD_EE_LAST_BYTE 4'd8
`define PVD_CLK_NS 100
`define PVD_I2C_QTR_NS 2500
`define PVD_I2C_QTR_CYC (`PVD_I2C_QTR_NS / `PVD_CLK_NS)
`endif

// *** logic/pvd_top.sv ***
// configuration header, eeprom loader and three video dma channels
//
// Contract
// - status word flags parity, master abort, target abort, data parity errors.
// - revision code sits read-only in low byte of word 08.
// - word 0C bits 15:8 hold writable latency timer limiting bus tenure.
// - memory window keeps bits 31:9 writable, low bits read zero.
// - subsystem identifiers load over serial bus, zero when nothing loaded.
// - max latency and min grant load serially, defaulting 26H and 0FH.
// - interrupt pin field reads fixed code for first interrupt line.
// - interrupt line byte of word 3C is writable by software.
// - three independent video dma channels exist.
// - each channel has fifo, video side input and bus side controller.
// - channel 1 only writes memory; only channels 2, 3 read.
// - each channel has own bases, pitch, protection, page, modes, enable.
// - each channel holds fifo threshold and burst length for arbitration.
// - line and byte counts per channel; channel 3 adds vertical ratio.
// - programming set may be replaced after transfer done marks completion.
// - dma registers reached by memory access at base plus offset.
// - fifo 1 holds 128 dwords written from scaler into memory.
// - fifo 2 carries U data out, or reads clip data in.
// - fifo 3 carries V, key or second scaler data out.
// - channel 3 read mode repeats each word up to four times.
// - address parity error means no claim; data parity errors drive error pin.
// - eeprom at address 1010000 loads; accesses during load get retry.
// - unimplemented configuration registers read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "pvd_regs.svh"

module pvd_top import pvd_pkg::*; #(
  parameter logic [15:0] P_VENDOR = 16'h5A5A, // arbitrary value
  parameter logic [15:0] P_DEVICE = 16'h0C3E, // arbitrary value
  parameter logic [7:0] P_REVISION = 8'h3B // arbitrary value
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // slave access from the bus
  input wire logic i_req_valid,
  input wire pvd_req_type i_req,
  input wire logic i_req_addr_perr,
  input wire logic i_req_data_perr,
  output logic o_ack,
  output logic o_retry,
  output logic [31:0] o_rdata,
  output logic o_perr,
  // serial eeprom, open drain
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe,
  // video side
  input wire logic i_field_odd,
  input wire logic [2:0] i_vid_in_valid,
  input wire logic [2:0][31:0] i_vid_in_data,
  output logic [2:0] o_vid_in_ready,
  output logic [2:0] o_vid_out_valid,
  output logic [2:0][31:0] o_vid_out_data,
  input wire logic [2:0] i_vid_out_ready,
  output logic [2:0] o_vtd,
  // bus master
  output logic o_mst_req,
  output pvd_mst_type o_mst,
  input wire logic i_mst_ack,
  input wire logic [31:0] i_mst_rdata,
  input wire logic i_mst_master_abort,
  input wire logic i_mst_target_abort,
  input wire logic i_mst_data_perr
);

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        old[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return old;
  endfunction

  function automatic logic [8:0] prog_off(input int c, input int k);
    if (k < 6) begin
      return 9'(c * 24 + k * 4);
    end
    return 9'(256 + c * 16 + (k - 6) * 4);
  endfunction

  // ****************************************
  // slave decode
  // ****************************************
  logic cmd_fbb_reg, cmd_per_reg, cmd_bme_reg, cmd_mem_reg;
  logic st_dpe_reg, st_rma_reg, st_rta_reg, st_mdpe_reg;
  logic [7:0] lat_reg, intline_reg, maxlat_reg, mingnt_reg;
  logic [31:`PVD_BAR_LSB] bar_reg;
  logic [31:0] subsys_reg;
  logic loading;
  logic [2:0][31:0] ch_rd, ch_addr, ch_head;
  logic [2:0][7:0] ch_burst;
  logic [2:0] want, rd_mode;
  logic gnt_vld_reg;
  logic [1:0] gnt_reg;

  wire [7:0] cfg_off = {i_req.addr[7:2], 2'b00};
  wire [8:0] mem_off = {i_req.addr[8:2], 2'b00};
  // window compare on writable bits only
  wire mem_hit = !i_req.cfg && cmd_mem_reg &&
                 i_req.addr[31:`PVD_BAR_LSB] == bar_reg;
  wire claim = i_req_valid && !i_req_addr_perr && (i_req.cfg || mem_hit);
  wire wr_ok = claim && !loading && i_req.write;
  wire cfg_wr = wr_ok && i_req.cfg;
  // memory writes at base plus offset
  wire mem_wr = wr_ok && !i_req.cfg;
  wire [31:0] wd = i_req.wdata;
  wire [3:0] be = i_req.be;
  wire [31:0] stcmd = {st_dpe_reg, 1'b0, st_rma_reg, st_rta_reg, 1'b0,
      2'b01, st_mdpe_reg, 1'b1, 7'h00, 6'h00, cmd_fbb_reg, 2'b00,
      cmd_per_reg, 3'b000, cmd_bme_reg, cmd_mem_reg, 1'b0};
  // unimplemented offsets fall through to zero
  wire [31:0] cfg_rd =
      (cfg_off == `PVD_CFG_IDENT) ? {P_DEVICE, P_VENDOR} :
      (cfg_off == `PVD_CFG_STCMD) ? stcmd :
      (cfg_off == `PVD_CFG_CLASS) ? {`PVD_CLASS_CODE, P_REVISION} :
      (cfg_off == `PVD_CFG_LAT) ? {16'h0000, lat_reg, 8'h00} :
      (cfg_off == `PVD_CFG_BAR) ? {bar_reg, 9'h000} :
      (cfg_off == `PVD_CFG_SUBSYS) ? subsys_reg :
      (cfg_off == `PVD_CFG_INTR) ?
        {maxlat_reg, mingnt_reg, `PVD_INT_PIN, intline_reg} : 32'h0000_0000;
  wire [31:0] mem_rd = ch_rd[0] | ch_rd[1] | ch_rd[2];
  wire cfg_w_sc = cfg_wr && cfg_off == `PVD_CFG_STCMD;
  // byte lanes merged on the full word, only bits 31:9 are kept
  wire [31:0] bar_merged = merge({bar_reg, 9'h000}, wd, be);

  // error flags: event sets win over write-one clears
  wire set_dpe = (i_req_valid && i_req_addr_perr) ||
                 (wr_ok && i_req_data_perr) || i_mst_data_perr;
  wire set_mdpe = i_mst_data_perr && cmd_per_reg;
  wire clr_dpe = cfg_w_sc && be[3] && wd[31];
  wire clr_rma = cfg_w_sc && be[3] && wd[29];
  wire clr_rta = cfg_w_sc && be[3] && wd[28];
  wire clr_mdpe = cfg_w_sc && be[3] && wd[24];

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_ack <= 1'b0;
      o_retry <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_perr <= 1'b0;
      {cmd_fbb_reg, cmd_per_reg, cmd_bme_reg, cmd_mem_reg} <= 4'h0;
      {st_dpe_reg, st_rma_reg, st_rta_reg, st_mdpe_reg} <= 4'h0;
      lat_reg <= 8'h00;
      intline_reg <= 8'h00;
      bar_reg <= '0;
    end else begin
      o_ack <= claim;
      o_retry <= claim && loading;
      o_rdata <= (claim && !loading && !i_req.write) ?
                 (i_req.cfg ? cfg_rd : mem_rd) : 32'h0000_0000;
      // parity error pin, gated by parity response
      o_perr <= cmd_per_reg &&
                ((wr_ok && i_req_data_perr) || i_mst_data_perr);
      st_dpe_reg <= set_dpe || (st_dpe_reg && !clr_dpe);
      st_rma_reg <= i_mst_master_abort || (st_rma_reg && !clr_rma);
      st_rta_reg <= i_mst_target_abort || (st_rta_reg && !clr_rta);
      st_mdpe_reg <= set_mdpe || (st_mdpe_reg && !clr_mdpe);
      if (cfg_w_sc && be[1]) begin
        cmd_fbb_reg <= wd[9];
      end
      if (cfg_w_sc && be[0]) begin
        {cmd_per_reg, cmd_bme_reg, cmd_mem_reg} <= {wd[6], wd[2], wd[1]};
      end
      if (cfg_wr && cfg_off == `PVD_CFG_LAT && be[1]) begin
        lat_reg <= wd[15:8];
      end
      if (cfg_wr && cfg_off == `PVD_CFG_BAR) begin
        bar_reg <= bar_merged[31:`PVD_BAR_LSB];
      end
      if (cfg_wr && cfg_off == `PVD_CFG_INTR && be[0]) begin
        intline_reg <= wd[7:0];
      end
    end
  end

  // ****************************************
  // serial eeprom loader
  // ****************************************
  pvd_ld_type ld_reg;
  logic [7:0] qdiv_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg, byte_reg;
  logic [47:0] shift_reg;
  logic ack_ok_reg, sda_s1, sda_s2, sda_s3, sda_reg;
  wire tick = qdiv_reg == 8'(`PVD_I2C_QTR_CYC - 1);
  // fixed device address, write then read
  wire [7:0] tx_byte = (byte_reg == 4'd0) ? `PVD_EE_WR_ADDR :
                       (byte_reg == 4'd1) ? `PVD_EE_WORD : `PVD_EE_RD_ADDR;
  wire tx_bit = tx_byte[3'(4'd7 - bit_reg)];
  wire rx_last = byte_reg == `PVD_EE_LAST_BYTE;
  assign loading = ld_reg != LD_DONE;

  // sda is slow and far away; second and third stage must agree
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      {sda_s1, sda_s2, sda_s3, sda_reg} <= 4'hF;
    end else begin
      {sda_s1, sda_s2, sda_s3} <= {i_sda, sda_s1, sda_s2};
      if (sda_s2 == sda_s3) begin
        sda_reg <= sda_s3;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ld_reg <= LD_START;
      qdiv_reg <= 8'h00;
      q_reg <= 2'd0;
      {bit_reg, byte_reg} <= 8'h00;
      shift_reg <= '0;
      {ack_ok_reg, o_scl_oe, o_sda_oe} <= 3'b000;
      // defaults stand unless a load completes
      subsys_reg <= 32'h0000_0000;
      maxlat_reg <= `PVD_MAXLAT_RST;
      mingnt_reg <= `PVD_MINGNT_RST;
    end else if (loading) begin
      qdiv_reg <= tick ? 8'h00 : qdiv_reg + 8'h01;
      if (tick) begin
        q_reg <= q_reg + 2'd1;
        case (ld_reg)
          LD_START: begin
            case (q_reg)
              2'd0: o_sda_oe <= 1'b0;
              2'd1: o_scl_oe <= 1'b0;
              2'd2: o_sda_oe <= 1'b1;
              default: begin
                o_scl_oe <= 1'b1;
                ld_reg <= LD_TX;
              end
            endcase
          end
          LD_TX, LD_RX: begin
            case (q_reg)
              2'd0: o_sda_oe <= (ld_reg == LD_TX) ?
                  (bit_reg != 4'd8 && !tx_bit) :
                  (bit_reg == 4'd8 && !rx_last);
              2'd1: o_scl_oe <= 1'b0;
              2'd2: begin
                if (bit_reg == 4'd8) begin
                  ack_ok_reg <= !sda_reg;
                end else if (ld_reg == LD_RX) begin
                  shift_reg <= {shift_reg[46:0], sda_reg};
                end
              end
              default: begin
                o_scl_oe <= 1'b1;
                bit_reg <= (bit_reg == 4'd8) ? 4'd0 : bit_reg + 4'd1;
                if (bit_reg == 4'd8) begin
                  byte_reg <= byte_reg + 4'd1;
                  if (ld_reg == LD_RX) begin
                    ld_reg <= rx_last ? LD_STOP : LD_RX;
                  end else if (!ack_ok_reg) begin
                    ld_reg <= LD_STOP;
                  end else begin
                    ld_reg <= (byte_reg == 4'd1) ? LD_START :
                              (byte_reg == 4'd2) ? LD_RX : LD_TX;
                  end
                end
              end
            endcase
          end
          LD_STOP: begin
            case (q_reg)
              2'd0: o_sda_oe <= 1'b1;
              2'd1: o_scl_oe <= 1'b0;
              2'd2: o_sda_oe <= 1'b0;
              default: begin
                ld_reg <= LD_DONE;
                // commit only after all bytes arrived
                if (byte_reg == `PVD_EE_LAST_BYTE + 4'd1) begin
                  subsys_reg <= {shift_reg[23:16], shift_reg[31:24],
                                 shift_reg[39:32], shift_reg[47:40]};
                  mingnt_reg <= shift_reg[15:8];
                  maxlat_reg <= shift_reg[7:0];
                end
              end
            endcase
          end
          default: ld_reg <= LD_DONE;
        endcase
      end
    end
  end

  // ****************************************
  // video dma channels
  // ****************************************
  // three channels
  for (genvar c = 0; c < 3; c++) begin : g_ch
    logic [31:0] prog_reg [0:7];
    logic [31:0] fifo_mem [0:127];
    logic [6:0] wptr_reg, rptr_reg;
    logic [7:0] cnt_reg;
    logic [31:0] line_reg, out_dat_reg, rd_v;
    logic [9:0] pos_reg;
    logic [11:0] lines_reg;
    logic [1:0] rep_reg;
    logic act_reg, done_reg, in_rdy_reg, out_vld_reg;
    // write masks keep channel abilities apart
    wire [31:0] ctl_mask = (c == 0) ? `PVD_CTL_WMASK_CH1 :
        (c == 1) ? `PVD_CTL_WMASK_CH2 : `PVD_CTL_WMASK_CH3;
    wire rd_m = prog_reg[7][`PVD_CTL_READ];
    wire en = prog_reg[7][`PVD_CTL_TREN];
    // repeat count only exists on channel 3
    wire [1:0] rep_max = prog_reg[7][`PVD_CTL_REP_LSB +: 2];
    wire [9:0] words = prog_reg[5][11:2];
    wire [11:0] nlines = prog_reg[5][27:16];
    // threshold of zero acts as one
    wire [7:0] thr = (prog_reg[6][7:0] == 8'h00) ? 8'h01 : prog_reg[6][7:0];
    wire bus_ack = i_mst_ack && gnt_vld_reg && gnt_reg == 2'(c);
    wire consume = out_vld_reg && i_vid_out_ready[c];
    wire last_rep = rep_reg == rep_max;
    wire out_load = rd_m && cnt_reg != 8'h00 &&
                    (!out_vld_reg || (consume && last_rep));
    // fifo filled by video or by memory reads
    wire push = rd_m ? bus_ack : (i_vid_in_valid[c] && in_rdy_reg);
    wire pop = rd_m ? out_load : bus_ack;
    wire start = en && !act_reg && !done_reg;
    wire eol = pos_reg + 10'd1 == words;
    wire fin = bus_ack && eol && lines_reg + 12'd1 == nlines;
    wire w_stat = mem_wr && mem_off == 9'(`PVD_EXT_BASE +
                  c * `PVD_EXT_STRIDE + `PVD_EXT_STAT);

    assign rd_mode[c] = rd_m;
    assign ch_burst[c] = prog_reg[6][15:8];
    assign ch_head[c] = fifo_mem[rptr_reg];
    assign ch_addr[c] = line_reg + {20'h00000, pos_reg, 2'b00};
    assign want[c] = act_reg && (rd_m ? (`PVD_FIFO_DEPTH - cnt_reg) >= thr :
                                        cnt_reg >= thr);
    assign ch_rd[c] = rd_v;
    assign o_vid_in_ready[c] = in_rdy_reg;
    assign o_vid_out_valid[c] = out_vld_reg;
    assign o_vid_out_data[c] = out_dat_reg;
    assign o_vtd[c] = done_reg;

    always_comb begin
      rd_v = 32'h0000_0000;
      for (int k = 0; k < 8; k++) begin
        if (claim && mem_off == prog_off(c, k)) begin
          rd_v = prog_reg[k];
        end
      end
      if (claim && mem_off == 9'(`PVD_EXT_BASE + c * `PVD_EXT_STRIDE +
                                 `PVD_EXT_STAT)) begin
        rd_v = {16'h0000, cnt_reg, 6'h00, act_reg, done_reg};
      end
    end

    always_ff @(posedge i_clk_sys) begin
      if (push) begin
        fifo_mem[wptr_reg] <= rd_m ? i_mst_rdata : i_vid_in_data[c];
      end
    end

    // programming set writes, by memory access
    always_ff @(posedge i_clk_sys) begin
      for (int k = 0; k < 8; k++) begin
        if (!i_reset_n) begin
          prog_reg[k] <= 32'h0000_0000;
        end else if (mem_wr && mem_off == prog_off(c, k)) begin
          prog_reg[k] <= merge(prog_reg[k], wd, be) &
              ((k == 2) ? `PVD_PROT_WMASK : (k == 4) ? `PVD_PAGE_WMASK :
               (k == 5) ? `PVD_LB_WMASK : (k == 6) ? `PVD_TB_WMASK :
               (k == 7) ? ctl_mask : 32'hFFFF_FFFF);
        end
      end
    end

    always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
        {wptr_reg, rptr_reg} <= 14'h0000;
        cnt_reg <= 8'h00;
        {in_rdy_reg, out_vld_reg, act_reg, done_reg} <= 4'h0;
        out_dat_reg <= 32'h0000_0000;
        rep_reg <= 2'd0;
        line_reg <= 32'h0000_0000;
        pos_reg <= 10'h000;
        lines_reg <= 12'h000;
      end else begin
        wptr_reg <= wptr_reg + 7'(push);
        rptr_reg <= rptr_reg + 7'(pop);
        cnt_reg <= cnt_reg + 8'(push) - 8'(pop);
        // one slot of slack since ready is a registered view of the count
        in_rdy_reg <= en && !rd_m && cnt_reg < `PVD_FIFO_NEAR_FULL;
        if (out_load) begin
          out_dat_reg <= ch_head[c];
          out_vld_reg <= 1'b1;
          rep_reg <= 2'd0;
        end else if (consume) begin
          // hold the word until repeated enough times
          out_vld_reg <= !last_rep;
          rep_reg <= last_rep ? 2'd0 : rep_reg + 2'd1;
        end
        // done flag: completion wins over write-one clear
        done_reg <= fin || (done_reg && !(w_stat && be[0] && wd[0]));
        if (!en) begin
          act_reg <= 1'b0;
        end else if (start) begin
          line_reg <= i_field_odd ? prog_reg[0] : prog_reg[1];
          pos_reg <= 10'h000;
          lines_reg <= 12'h000;
          act_reg <= 1'b1;
        end else if (bus_ack) begin
          pos_reg <= eol ? 10'h000 : pos_reg + 10'h001;
          if (eol) begin
            line_reg <= line_reg + prog_reg[3];
            lines_reg <= lines_reg + 12'h001;
          end
          if (fin) begin
            act_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************
  // bus arbitration and master port
  // ****************************************
  logic [7:0] burst_cnt_reg, lat_cnt_reg;
  wire [2:0] req_v = want & {3{cmd_bme_reg}};
  wire [1:0] pick = req_v[0] ? 2'd0 : req_v[1] ? 2'd1 : 2'd2;
  wire [7:0] blen = (ch_burst[gnt_reg] == 8'h00) ? 8'h01 : ch_burst[gnt_reg];
  wire lat_out = lat_reg != 8'h00 && lat_cnt_reg >= lat_reg;
  wire release_now = !req_v[gnt_reg] || lat_out ||
      i_mst_master_abort || i_mst_target_abort ||
      (i_mst_ack && burst_cnt_reg + 8'h01 >= blen);

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      gnt_vld_reg <= 1'b0;
      gnt_reg <= 2'd0;
      {burst_cnt_reg, lat_cnt_reg} <= 16'h0000;
      o_mst_req <= 1'b0;
      o_mst <= '0;
    end else begin
      // no mastering without bus master enable
      o_mst_req <= gnt_vld_reg && !release_now && !i_mst_ack;
      // direction follows read mode, never read on channel 1
      o_mst <= {!rd_mode[gnt_reg], gnt_reg, ch_addr[gnt_reg],
                ch_head[gnt_reg]};
      if (!gnt_vld_reg) begin
        // fixed priority grant, burst bounded per tenure
        gnt_vld_reg <= req_v != 3'b000;
        gnt_reg <= pick;
        {burst_cnt_reg, lat_cnt_reg} <= 16'h0000;
      end else begin
        lat_cnt_reg <= lat_out ? lat_cnt_reg : lat_cnt_reg + 8'h01;
        burst_cnt_reg <= burst_cnt_reg + 8'(i_mst_ack);
        gnt_vld_reg <= !release_now;
      end
    end
  end

endmodule // pvd_top
`default_nettype wire

// *** tb/pvd_bus_agent.sv ***
// memory-side bus agent answering the master port
`timescale 1ns/1ps
`default_nettype none
// ****
// agent
// ****
module pvd_bus_agent import pvd_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_mst_req,
  input wire pvd_mst_type i_mst,
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic o_abort
);
  logic [1:0] wait_reg;
  logic go;
  // delay taken from address bits so some words answer late
  assign go = i_mst_req && !o_ack && wait_reg == i_mst.addr[9:8];
  assign o_abort = 1'b0;
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      wait_reg <= 2'h0;
      o_ack <= 1'b0;
      o_rdata <= 32'h0;
    end else begin
      o_ack <= go;
      wait_reg <= (i_mst_req && !o_ack) ? wait_reg + 2'h1 : 2'h0;
      // read data toggles outside an answer, never holds stale
      o_rdata <= go ? ~i_mst.addr : ~o_rdata;
    end
  end
endmodule // pvd_bus_agent
`default_nettype wire

// *** tb/pvd_chk_sva.sv ***
// port assertions for the pvd block
`timescale 1ns/1ps
`default_nettype none
`include "pvd_regs.svh"
// ****
// checker
// ****
module pvd_chk_sva import pvd_pkg::*; #(
  parameter logic [7:0] P_REVISION = 8'h3B
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_req_valid,
  input wire pvd_req_type i_req,
  input wire logic i_req_addr_perr,
  input wire logic o_ack,
  input wire logic o_retry,
  input wire logic [31:0] o_rdata,
  input wire logic o_mst_req,
  input wire pvd_mst_type o_mst,
  input wire logic i_mst_ack
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic c_rd;
  assign c_rd = i_req_valid && i_req.cfg && !i_req.write && !i_req_addr_perr;
  cfg_claim_a: assert property (
    i_req_valid && i_req.cfg && !i_req_addr_perr |=> o_ack)
    else $error("config access not answered");
  perr_noclaim_a: assert property (
    i_req_valid && i_req_addr_perr |=> !o_ack) else $error("bad claim");
  ack_cause_a: assert property (!i_req_valid |=> !o_ack)
    else $error("ack without request");
  retry_ack_a: assert property (o_retry |-> o_ack)
    else $error("retry without ack");
  rev_read_a: assert property (c_rd && i_req.addr[7:0] == 8'h08 |=>
    o_retry || o_rdata == {24'h048000, P_REVISION}) else $error("rev");
  int_pin_a: assert property (c_rd && i_req.addr[7:0] == 8'h3C |=>
    o_retry || o_rdata[15:8] == 8'h01) else $error("int pin");
  bar_low_a: assert property (c_rd && i_req.addr[7:0] == 8'h10 |=>
    o_retry || o_rdata[8:0] == 9'h000) else $error("window low bits");
  mst_hold_a: assert property (o_mst_req && $past(o_mst_req) &&
    !$past(i_mst_ack) |-> $stable(o_mst)) else $error("master moved");
  mst_drop_a: assert property (i_mst_ack |=> !o_mst_req)
    else $error("request held after ack");
  cover property (o_ack && o_retry);
  cover property (o_ack && !o_retry);
  cover property (o_mst_req && i_mst_ack);
endmodule // pvd_chk_sva
bind pvd_top pvd_chk_sva #(.P_REVISION(P_REVISION)) pvd_chk_sva_inst (
  .i_clk_sys, .i_reset_n, .i_req_valid, .i_req, .i_req_addr_perr, .o_ack,
  .o_retry, .o_rdata, .o_mst_req, .o_mst, .i_mst_ack);
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the pvd block
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module tb import pvd_pkg::*; ;
  localparam logic [31:0] ID = 32'h0C3E_5A5A; // arbitrary value
  localparam logic [7:0] REV = 8'h3B; // arbitrary value
  localparam logic [31:0] BAR = 32'h8000_0000;
  logic clk = 1'b0, rst_n = 1'b0, rv = 1'b0, ap = 1'b0, ack, retry, perr;
  logic scl_oe, sda_oe, mreq, mack, abort;
  logic [31:0] rdata, mrd, lfsr = 32'd79;
  logic [2:0] vin_v = 3'h0, vin_rdy, vout_v, video_transfer_done;
  logic [2:0][31:0] vin_d = '0, vout_d;
  pvd_req_type req = '0;
  pvd_mst_type mst;
  int n_mismatch = 0, n_checks = 0, k;
  int unsigned mdl [int];
  logic [31:0] aq [$], dq [$], sq [$];
  pvd_top #(.P_VENDOR(ID[15:0]), .P_DEVICE(ID[31:16]), .P_REVISION(REV))
  pvd_top_inst (.i_clk_sys(clk), .i_reset_n(rst_n), .i_req_valid(rv),
    .i_req(req), .i_req_addr_perr(ap), .i_req_data_perr(1'b0), .o_ack(ack),
    .o_retry(retry), .o_rdata(rdata), .o_perr(perr), .i_sda(!sda_oe),
    .o_scl_oe(scl_oe), .o_sda_oe(sda_oe), .i_field_odd(1'b1),
    .i_vid_in_valid(vin_v), .i_vid_in_data(vin_d), .o_vid_in_ready(vin_rdy),
    .o_vid_out_valid(vout_v), .o_vid_out_data(vout_d),
    .i_vid_out_ready(3'h7), .o_vtd(video_transfer_done), .o_mst_req(mreq), .o_mst(mst),
    .i_mst_ack(mack), .i_mst_rdata(mrd), .i_mst_master_abort(abort),
    .i_mst_target_abort(abort), .i_mst_data_perr(1'b0));
  pvd_bus_agent pvd_bus_agent_inst (.i_clk_sys(clk), .i_reset_n(rst_n),
    .i_mst_req(mreq), .i_mst(mst), .o_ack(mack), .o_rdata(mrd),
    .o_abort(abort));
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] wm(input int a);
    case (a)
      4: return 32'h0000_0246;
      'h0C: return 32'h0000_FF00;
      'h10: return 32'hFFFF_FE00;
      'h3C: return 32'h0000_00FF;
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic c, w, p, input logic [31:0] a, d);
    @(negedge clk);
    rv = 1'b1;
    ap = p;
    req = '{c, w, a, 4'hF, d};
    @(negedge clk);
    rv = 1'b0;
    ap = 1'b0;
    // the answer stands until the next rising edge, so callers read it now
  endtask
  task automatic cw(input int a, input logic [31:0] d);
    acc(1'b1, 1'b1, 1'b0, a, d);
    mdl[a] = (mdl[a] & ~wm(a)) | (d & wm(a));
  endtask
  task automatic cr(input int a);
    acc(1'b1, 1'b0, 1'b0, a, 32'h0);
    chk(rdata, mdl[a]);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) if (mreq === 1'b1 && mack === 1'b1) begin
    aq.push_back(mst.addr);
    dq.push_back(mst.wdata);
    chk(mst.write, 1'b1);
  end
  initial begin
    #(30000 * 100);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    for (int a = 0; a < 64; a += 4) mdl[a] = 0;
    mdl[0] = ID;
    mdl[4] = 32'h0280_0000;
    mdl[8] = {24'h048000, REV};
    mdl['h3C] = 32'h260F_0100;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    acc(1'b1, 1'b0, 1'b0, 32'h8, 32'h0);
    chk(retry, 1'b1);
    for (k = 0; k < 3000 && retry === 1'b1; k++) acc(1, 0, 0, 32'h8, 0);
    for (int a = 0; a < 64; a += 4) cr(a);
    cw('h10, 32'hFFFF_FFFF);
    cw('h0C, 32'hFFFF_FFFF);
    cw('h3C, 32'hFFFF_FF5A);
    cw(8, 32'hFFFF_FFFF);
    cw(0, 32'hFFFF_FFFF);
    for (int a = 0; a < 64; a += 4) cr(a);
    cw('h10, BAR);
    acc(1'b0, 1'b0, 1'b0, BAR, 32'h0);
    chk(ack, 1'b0);
    cw(4, 32'hFFFF_FFFF);
    acc(1'b1, 1'b0, 1'b1, 32'h8, 32'h0);
    chk(ack, 1'b0);
    acc(1'b1, 1'b0, 1'b0, 32'h4, 32'h0);
    chk(rdata[31], 1'b1);
    acc(1'b0, 1'b0, 1'b0, 32'h4000_0000, 32'h0);
    chk(ack, 1'b0);
    $display("test config done");
    // set written while idle, before enabling the channel
    acc(0, 1, 0, BAR + 'h104, 32'h2);
    acc(0, 0, 0, BAR + 'h104, 32'h0);
    chk(rdata, 32'h0);
    acc(0, 1, 0, BAR, 32'h1000);
    acc(0, 1, 0, BAR + 4, 32'h2000);
    acc(0, 1, 0, BAR + 'h0C, 32'h100);
    acc(0, 1, 0, BAR + 'h14, 32'h0002_0004);
    acc(0, 1, 0, BAR + 'h100, 32'h0101);
    acc(0, 1, 0, BAR + 'h104, 32'h1);
    for (int i = 0; i < 2; i++) begin
      lfsr = nxt(lfsr);
      vin_d[0] = lfsr;
      vin_v[0] = 1'b1;
      sq.push_back(lfsr);
      for (k = 0; k < 200 && vin_rdy[0] !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
    end
    vin_v[0] = 1'b0;
    for (k = 0; k < 500 && video_transfer_done[0] !== 1'b1; k++) @(negedge clk);
    chk(video_transfer_done[0], 1'b1);
    chk(aq.size(), 2);
    for (int i = 0; i < 2 && i < aq.size(); i++) begin
      chk(aq[i], 32'h1000 + i * 32'h100);
      chk(dq[i], sq[i]);
    end
    acc(0, 0, 0, BAR + 'h108, 32'h0);
    chk(rdata[0], 1'b1);
    $display("test channel done");
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
